// [hdl/npm_pkg.sv]
package npm_pkg;

  // Block power state, one-hot
  typedef enum logic [1:0]
  {
    NPM_BLK_ACTIVE    = 2'b01,
    NPM_BLK_RETENTION = 2'b10
  } npm_blk_e;

  // Networking subsystem mode
  localparam logic [1:0] NPM_NET_DISABLED   = 2'h0;
  localparam logic [1:0] NPM_NET_DEEP_SLEEP = 2'h1;
  localparam logic [1:0] NPM_NET_ACTIVE     = 2'h2;

  // Application CPU mode as written by software
  localparam logic [2:0] NPM_CPU_SHUTDOWN  = 3'h0;
  localparam logic [2:0] NPM_CPU_HIBERNATE = 3'h1;
  localparam logic [2:0] NPM_CPU_DEEP      = 3'h2;
  localparam logic [2:0] NPM_CPU_SLEEP     = 3'h3;
  localparam logic [2:0] NPM_CPU_ACTIVE    = 3'h4;

  // Chip-level mode
  localparam logic [1:0] NPM_CHIP_SHUTDOWN  = 2'h0;
  localparam logic [1:0] NPM_CHIP_HIBERNATE = 2'h1;
  localparam logic [1:0] NPM_CHIP_DEEP      = 2'h2;
  localparam logic [1:0] NPM_CHIP_ACTIVE    = 2'h3;

  // Register byte addresses
  localparam logic [7:0] NPM_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] NPM_ADDR_STATUS = 8'h04;
  localparam logic [7:0] NPM_ADDR_EVENT  = 8'h08;

  // Control field positions
  localparam int NPM_CTRL_CPU_LSB  = 0;
  localparam int NPM_CTRL_NET_EN   = 4;
  localparam int NPM_CTRL_WIDTH    = 5;

  // Reset values
  localparam logic [2:0] NPM_CPU_RESET    = 3'h4;
  localparam logic       NPM_NET_EN_RESET = 1'b0;

  // Idle threshold before a block may enter retention
  localparam int         NPM_IDLE_NS    = 1000;
  localparam int         NPM_CLK_NS     = 5;
  localparam logic [7:0] NPM_IDLE_CYC   = 8'((NPM_IDLE_NS + NPM_CLK_NS - 1) / NPM_CLK_NS);
  // Slow clock settle time on a cold boot, boot time otherwise
  localparam int         NPM_SLOWCLK_NS = 2000;
  localparam logic [9:0] NPM_COLD_CYC   = 10'((NPM_SLOWCLK_NS + NPM_CLK_NS - 1) / NPM_CLK_NS);
  localparam logic [9:0] NPM_WARM_CYC   = 10'h010;

endpackage : npm_pkg

// [hdl/npm_blk_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface npm_blk_if;
  import npm_pkg::*;
  logic     busy;
  logic     hold;
  npm_blk_e state;
  modport ctl (input busy, input hold, output state);
  modport top (output busy, output hold, input state);
endinterface : npm_blk_if
`default_nettype wire

// [hdl/npm_blk_sleep.sv]
`timescale 1ns/100ps
`default_nettype none
module npm_blk_sleep
  import npm_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  reset,
  input  wire logic  enable,
  npm_blk_if.ctl     blk
);
  logic [7:0] idle_cnt;
  logic [7:0] next_idle_cnt;
  npm_blk_e   next_state;
  wire        can_sleep = !blk.busy && !blk.hold && idle_cnt == NPM_IDLE_CYC;

  assign next_idle_cnt = (blk.busy || !enable) ? 8'h00 :
                         (idle_cnt == NPM_IDLE_CYC) ? idle_cnt : idle_cnt + 8'h01;

  // Each block decides alone; pending work always wakes it
  always_comb
  begin
    next_state = blk.state;
    case (blk.state)
      NPM_BLK_ACTIVE:    if (enable && can_sleep) next_state = NPM_BLK_RETENTION;
      NPM_BLK_RETENTION: if (!enable || blk.busy || blk.hold) next_state = NPM_BLK_ACTIVE;
      default:           next_state = NPM_BLK_ACTIVE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      blk.state <= NPM_BLK_ACTIVE;
      idle_cnt  <= 8'h00;
    end
    else
    begin
      blk.state <= next_state;
      idle_cnt  <= next_idle_cnt;
    end
  end

  property p_busy_wakes;
    @(posedge clk) disable iff (reset)
      blk.busy |=> blk.state == NPM_BLK_ACTIVE;
  endproperty
  a_busy_wakes: assert property (p_busy_wakes) else $error("busy block stayed retained");

  property p_idle_sleeps;
    @(posedge clk) disable iff (reset)
      (enable && !blk.busy && !blk.hold)[*8] ##1 (enable && !blk.busy && !blk.hold)
        |-> ##[0:200] blk.state == NPM_BLK_RETENTION;
  endproperty
  a_idle_sleeps: assert property (p_idle_sleeps) else $error("idle block never slept");
endmodule : npm_blk_sleep
`default_nettype wire

// [hdl/npm_power_mgr.sv]
`timescale 1ns/100ps
`default_nettype none
module npm_power_mgr
  import npm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        net_proc_busy,
  input  wire logic        radio_busy,
  input  wire logic        net_event,
  output logic             event_irq,
  output logic             supply_low,
  output logic             xtal_en,
  output logic             pll_en,
  output logic             mem_retain,
  output logic             rtc_run,
  output logic             logic_gated,
  output logic             cpu_reset_vector,
  output logic             net_boot_busy,
  output logic             net_boot_cold,
  output logic [1:0]       net_mode,
  output logic [1:0]       chip_mode
);
  import npm_pkg::*;

  npm_blk_if proc_if ();
  npm_blk_if radio_if ();

  logic [2:0] cpu_mode;
  logic       net_en;
  logic       event_pend;
  logic [9:0] boot_cnt;
  logic       boot_cold;
  logic       was_hibernate;
  logic [1:0] prev_chip;
  logic       blocks_en;

  wire wr_en     = psel && penable && pwrite;
  wire rd_en     = psel && penable && !pwrite;
  wire hit_ctrl  = paddr == NPM_ADDR_CTRL;
  wire hit_stat  = paddr == NPM_ADDR_STATUS;
  wire hit_event = paddr == NPM_ADDR_EVENT;
  wire mapped    = hit_ctrl || hit_stat || hit_event;
  wire [2:0] wr_cpu = pwdata[NPM_CTRL_CPU_LSB +: 3];
  // Hibernate with networking enabled is not a legal pairing; refused
  wire wr_legal  = !(wr_cpu == NPM_CPU_HIBERNATE && pwdata[NPM_CTRL_NET_EN]);
  wire ctrl_wr   = wr_en && hit_ctrl && wr_legal && wr_cpu <= NPM_CPU_ACTIVE;
  wire ev_rd     = rd_en && hit_event;

  // Subsystem mode from block states
  function automatic logic [1:0] net_of(input logic en, input npm_blk_e a, input npm_blk_e b);
    if (!en)
      return NPM_NET_DISABLED;
    else if (a == NPM_BLK_RETENTION && b == NPM_BLK_RETENTION)
      return NPM_NET_DEEP_SLEEP;
    else
      return NPM_NET_ACTIVE;
  endfunction : net_of

  // Chip mode from CPU mode and subsystem mode
  function automatic logic [1:0] chip_of(input logic [2:0] cpu, input logic [1:0] net);
    if (cpu == NPM_CPU_SLEEP || cpu == NPM_CPU_ACTIVE)
      return NPM_CHIP_ACTIVE;
    else if (cpu == NPM_CPU_HIBERNATE)
      return NPM_CHIP_HIBERNATE;
    else if (cpu == NPM_CPU_DEEP)
      return (net == NPM_NET_ACTIVE) ? NPM_CHIP_ACTIVE : NPM_CHIP_DEEP;
    else
      return NPM_CHIP_SHUTDOWN;
  endfunction : chip_of

  // Blocks run only after boot completes
  assign blocks_en      = net_en && boot_cnt == 10'h000;
  assign proc_if.busy   = net_proc_busy || event_pend || !blocks_en;
  assign proc_if.hold   = event_pend;
  assign radio_if.busy  = radio_busy || !blocks_en;
  assign radio_if.hold  = event_pend;

  npm_blk_sleep u_proc
  (
    .clk    (clk),
    .reset  (reset),
    .enable (blocks_en),
    .blk    (proc_if.ctl)
  );

  npm_blk_sleep u_radio
  (
    .clk    (clk),
    .reset  (reset),
    .enable (blocks_en),
    .blk    (radio_if.ctl)
  );

  wire [1:0] next_net_mode  = net_of(blocks_en, proc_if.state, radio_if.state);
  wire [1:0] next_chip_mode = chip_of(cpu_mode, next_net_mode);
  wire       chip_deep      = next_chip_mode == NPM_CHIP_DEEP;
  wire       chip_hib       = next_chip_mode == NPM_CHIP_HIBERNATE;
  wire       chip_off       = next_chip_mode == NPM_CHIP_SHUTDOWN;
  // Enable edge starts a boot whose kind follows the prior power state
  wire       start_boot     = ctrl_wr && pwdata[NPM_CTRL_NET_EN] && !net_en;
  wire       wake_from_deep = prev_chip == NPM_CHIP_DEEP && !chip_deep;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cpu_mode <= NPM_CPU_RESET;
      net_en   <= NPM_NET_EN_RESET;
    end
    else if (ctrl_wr)
    begin
      cpu_mode <= wr_cpu;
      net_en   <= pwdata[NPM_CTRL_NET_EN];
    end
  end

  // Set wins over the clear by an event register read
  always_ff @(posedge clk)
  begin
    if (reset)
      event_pend <= 1'b0;
    else if (net_event && net_en)
      event_pend <= 1'b1;
    else if (ev_rd)
      event_pend <= 1'b0;
  end

  // Prior state remembered for the boot choice
  always_ff @(posedge clk)
  begin
    if (reset)
      was_hibernate <= 1'b0;
    else if (!net_en)
      was_hibernate <= cpu_mode == NPM_CPU_HIBERNATE || was_hibernate && cpu_mode != NPM_CPU_SHUTDOWN;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      boot_cnt  <= 10'h000;
      boot_cold <= 1'b1;
    end
    else if (start_boot)
    begin
      boot_cnt  <= was_hibernate ? NPM_WARM_CYC : NPM_COLD_CYC;
      boot_cold <= !was_hibernate;
    end
    else if (!net_en)
      boot_cnt  <= 10'h000;
    else if (boot_cnt != 10'h000)
      boot_cnt  <= boot_cnt - 10'h001;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      net_mode         <= NPM_NET_DISABLED;
      chip_mode        <= NPM_CHIP_ACTIVE;
      prev_chip        <= NPM_CHIP_ACTIVE;
      supply_low       <= 1'b0;
      xtal_en          <= 1'b1;
      pll_en           <= 1'b1;
      mem_retain       <= 1'b0;
      rtc_run          <= 1'b1;
      logic_gated      <= 1'b0;
      cpu_reset_vector <= 1'b0;
      event_irq        <= 1'b0;
      net_boot_busy    <= 1'b0;
      net_boot_cold    <= 1'b0;
    end
    else
    begin
      net_mode         <= next_net_mode;
      chip_mode        <= next_chip_mode;
      prev_chip        <= next_chip_mode;
      // Active: nominal supplies and all clocks, no software step needed
      supply_low       <= !(next_chip_mode == NPM_CHIP_ACTIVE);
      xtal_en          <= next_chip_mode == NPM_CHIP_ACTIVE;
      pll_en           <= next_chip_mode == NPM_CHIP_ACTIVE;
      mem_retain       <= chip_deep;
      rtc_run          <= !chip_off;
      logic_gated      <= chip_deep || chip_hib || chip_off;
      cpu_reset_vector <= wake_from_deep;
      event_irq        <= event_pend && net_en;
      net_boot_busy    <= start_boot || boot_cnt > 10'h001;
      net_boot_cold    <= start_boot ? !was_hibernate : boot_cold && boot_cnt > 10'h001;
    end
  end

  // APB: zero wait states, error on unmapped or refused access
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (!mapped || (pwrite && !hit_ctrl) || (wr_en && hit_ctrl && !ctrl_wr));

  always_ff @(posedge clk)
  begin
    if (reset)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      if (paddr == NPM_ADDR_CTRL)
        prdata <= {27'h0, net_en, 1'b0, cpu_mode};
      else if (paddr == NPM_ADDR_STATUS)
        prdata <= {20'h0, boot_cold, net_boot_busy, chip_mode, 2'h0, net_mode,
                   radio_if.state == NPM_BLK_RETENTION, proc_if.state == NPM_BLK_RETENTION, 2'h0};
      else if (paddr == NPM_ADDR_EVENT)
        prdata <= {31'h0, event_pend};
      else
        prdata <= 32'h0000_0000;
    end
  end

  property p_deep_both;
    @(posedge clk) disable iff (reset)
      (blocks_en && proc_if.state == NPM_BLK_RETENTION && radio_if.state == NPM_BLK_RETENTION)
        |=> net_mode == NPM_NET_DEEP_SLEEP;
  endproperty
  a_deep_both: assert property (p_deep_both) else $error("deep sleep not reported");

  property p_active_any;
    @(posedge clk) disable iff (reset)
      (blocks_en && (proc_if.state == NPM_BLK_ACTIVE || radio_if.state == NPM_BLK_ACTIVE))
        |=> net_mode == NPM_NET_ACTIVE;
  endproperty
  a_active_any: assert property (p_active_any) else $error("active not reported");

  property p_deep_clocks;
    @(posedge clk) disable iff (reset)
      chip_mode == NPM_CHIP_DEEP |-> !xtal_en && !pll_en && supply_low && mem_retain;
  endproperty
  a_deep_clocks: assert property (p_deep_clocks) else $error("deep sleep clocks wrong");

  property p_hib_rtc;
    @(posedge clk) disable iff (reset)
      chip_mode == NPM_CHIP_HIBERNATE |-> rtc_run && logic_gated && !mem_retain;
  endproperty
  a_hib_rtc: assert property (p_hib_rtc) else $error("hibernate outputs wrong");

  property p_off_rtc;
    @(posedge clk) disable iff (reset)
      chip_mode == NPM_CHIP_SHUTDOWN |-> !rtc_run && !mem_retain;
  endproperty
  a_off_rtc: assert property (p_off_rtc) else $error("shutdown outputs wrong");

  property p_active_clocks;
    @(posedge clk) disable iff (reset)
      chip_mode == NPM_CHIP_ACTIVE |-> xtal_en && pll_en && !supply_low && !logic_gated;
  endproperty
  a_active_clocks: assert property (p_active_clocks) else $error("active outputs wrong");

  property p_cpu_run;
    @(posedge clk) disable iff (reset)
      (cpu_mode == NPM_CPU_SLEEP || cpu_mode == NPM_CPU_ACTIVE) |=> chip_mode == NPM_CHIP_ACTIVE;
  endproperty
  a_cpu_run: assert property (p_cpu_run) else $error("cpu run not active");

  property p_cpu_deep;
    @(posedge clk) disable iff (reset)
      (cpu_mode == NPM_CPU_DEEP && !blocks_en) |=> chip_mode == NPM_CHIP_DEEP;
  endproperty
  a_cpu_deep: assert property (p_cpu_deep) else $error("cpu deep not followed");

  property p_wake_vector;
    @(posedge clk) disable iff (reset)
      (chip_mode == NPM_CHIP_DEEP ##1 chip_mode != NPM_CHIP_DEEP) |-> cpu_reset_vector;
  endproperty
  a_wake_vector: assert property (p_wake_vector) else $error("no reset vector restart");

  property p_warm_boot;
    @(posedge clk) disable iff (reset)
      (start_boot && was_hibernate) |=> boot_cnt == NPM_WARM_CYC && !net_boot_cold;
  endproperty
  a_warm_boot: assert property (p_warm_boot) else $error("warm boot not chosen");

  property p_irq_no_deep;
    @(posedge clk) disable iff (reset)
      event_pend |=> ##1 net_mode != NPM_NET_DEEP_SLEEP;
  endproperty
  a_irq_no_deep: assert property (p_irq_no_deep) else $error("deep sleep with event up");

  property p_irq_clear;
    @(posedge clk) disable iff (reset)
      (ev_rd && !net_event) |=> ##1 !event_irq;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("event line not cleared");

  property p_hold_ctrl;
    @(posedge clk) disable iff (reset)
      !ctrl_wr |=> $stable(cpu_mode) && $stable(net_en);
  endproperty
  a_hold_ctrl: assert property (p_hold_ctrl) else $error("mode changed without write");

  property p_cold_boot;
    @(posedge clk) disable iff (reset)
      (start_boot && !was_hibernate) |=> boot_cnt == NPM_COLD_CYC && net_boot_cold;
  endproperty
  a_cold_boot: assert property (p_cold_boot) else $error("cold boot not chosen");

  // Hibernate is only reachable with networking off, so the pair is never shown
  property p_hib_off;
    @(posedge clk) disable iff (reset)
      chip_mode == NPM_CHIP_HIBERNATE |-> net_mode == NPM_NET_DISABLED;
  endproperty
  a_hib_off: assert property (p_hib_off) else $error("hibernate with net on");

  property p_deep_gated;
    @(posedge clk) disable iff (reset)
      chip_mode == NPM_CHIP_DEEP |-> logic_gated && rtc_run;
  endproperty
  a_deep_gated: assert property (p_deep_gated) else $error("deep sleep not gated");

  // One cycle wide; a held level would restart the CPU a second time
  property p_vector_pulse;
    @(posedge clk) disable iff (reset)
      cpu_reset_vector |=> !cpu_reset_vector;
  endproperty
  a_vector_pulse: assert property (p_vector_pulse) else $error("restart held too long");

  property p_irq_set;
    @(posedge clk) disable iff (reset)
      (net_event && net_en) ##1 net_en |=> event_irq;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("event line not raised");
endmodule : npm_power_mgr
`default_nettype wire

// [tb/npm_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module npm_host_model
(
  input  wire logic        clk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  logic        last_err;
  logic [31:0] last_data;
  event        xfer_ev;
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end
  // Software sets only CPU mode and enable; power states run on their own
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    last_err  = pslverr;
    last_data = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines flip so a stale value never looks valid
    paddr   <= ~a;
    pwdata  <= ~d;
    -> xfer_ev;
  endtask : xfer
endmodule : npm_host_model
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import npm_pkg::*;
  typedef struct packed {logic err; logic [31:0] data; logic [31:0] mask;} npm_tb_bus_s;
  logic        clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic        net_proc_busy, radio_busy, net_event, event_irq, supply_low, xtal_en;
  logic        pll_en, mem_retain, rtc_run, logic_gated, cpu_reset_vector;
  logic        net_boot_busy, net_boot_cold;
  logic [1:0]  net_mode, chip_mode;
  npm_tb_bus_s bq[$];
  logic [25:0] pq[$];
  logic [2:0]  cpu_codes [2] = '{NPM_CPU_SLEEP, NPM_CPU_ACTIVE};
  int          err_count, total_checks, n, pulses;
  event        snap_ev;
  wire logic [12:0] ports = {net_mode, chip_mode, supply_low, xtal_en, pll_en, mem_retain,
                             rtc_run, logic_gated, event_irq, net_boot_busy, net_boot_cold};
  npm_power_mgr DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .net_proc_busy(net_proc_busy), .radio_busy(radio_busy),
    .net_event(net_event), .event_irq(event_irq), .supply_low(supply_low),
    .xtal_en(xtal_en), .pll_en(pll_en), .mem_retain(mem_retain), .rtc_run(rtc_run),
    .logic_gated(logic_gated), .cpu_reset_vector(cpu_reset_vector),
    .net_boot_busy(net_boot_busy), .net_boot_cold(net_boot_cold),
    .net_mode(net_mode), .chip_mode(chip_mode));
  npm_host_model host (.clk(clk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic cmp_bus(input logic e, input logic [31:0] d, input npm_tb_bus_s x);
    total_checks++;
    if (e !== x.err || ((d ^ x.data) & x.mask) !== 32'h0)
    begin
      err_count++;
      $display("wrong value at %0t: bus err %b data %h", $time, e, d);
    end
  endtask : cmp_bus
  task automatic cmp_ports(input logic [12:0] g, input logic [12:0] e, input logic [12:0] m);
    total_checks++;
    if (((g ^ e) & m) !== 13'h0)
    begin
      err_count++;
      $display("wrong value at %0t: ports %b expected %b", $time, g, e);
    end
  endtask : cmp_ports
  task automatic cmp_count(input int g, input int lo, input int hi);
    total_checks++;
    if (g < lo || g > hi)
    begin
      err_count++;
      $display("wrong value at %0t: count %0d", $time, g);
    end
  endtask : cmp_count
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic e, input logic [31:0] m);
    bq.push_back({e, d, m});
    host.xfer(w, a, d);
  endtask : bus
  task automatic expect_ports(input logic [12:0] e, input logic [12:0] m);
    pq.push_back({e, m});
    #1;
    -> snap_ev;
  endtask : expect_ports
  task automatic wait_deep(output int cnt);
    for (cnt = 0; cnt < 1000 && net_mode !== NPM_NET_DEEP_SLEEP; cnt++)
      @(posedge clk);
  endtask : wait_deep
  task automatic boot(input logic cold, input int cyc);
    int k;
    for (k = 0; k < 8 && net_boot_busy !== 1'b1; k++)
      @(posedge clk);
    expect_ports({11'h0, 1'b1, cold}, 13'h0003);
    for (k = 0; k < 1000 && net_boot_busy === 1'b1; k++)
      @(posedge clk);
    cmp_count(k, cyc - 3, cyc + 2);
    $display("boot test done");
  endtask : boot
  initial
  begin
    npm_tb_bus_s x;
    forever
    begin
      @(host.xfer_ev);
      x = bq.pop_front();
      cmp_bus(host.last_err, host.last_data, x);
    end
  end
  initial
  begin
    logic [25:0] y;
    forever
    begin
      @(snap_ev);
      y = pq.pop_front();
      cmp_ports(ports, y[25:13], y[12:0]);
    end
  end
  always @(posedge clk)
    if (cpu_reset_vector === 1'b1)
      pulses++;
  initial
  begin
    #100000;
    err_count++;
    $display("watchdog expired");
    test_done();
  end
  initial
  begin
    rnd = 32'h1068;
    reset = 1'b1;
    net_proc_busy = 1'b0;
    radio_busy = 1'b0;
    net_event = 1'b0;
    err_count = 0;
    total_checks = 0;
    pulses = 0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    expect_ports({NPM_NET_DISABLED, NPM_CHIP_ACTIVE, 9'b011010000}, 13'h1fff);
    bus(1'b0, NPM_ADDR_CTRL, 32'h4, 1'b0, 32'hffffffff);
    bus(1'b0, NPM_ADDR_STATUS, 32'hb00, 1'b0, 32'hfffffff3);
    // Refused accesses must leave control as it was
    bus(1'b1, 8'h0c, 32'h1, 1'b1, 32'h0);
    bus(1'b0, 8'h0c, 32'h0, 1'b1, 32'h0);
    bus(1'b1, NPM_ADDR_STATUS, 32'h1, 1'b1, 32'h0);
    bus(1'b1, NPM_ADDR_EVENT, 32'h1, 1'b1, 32'h0);
    for (n = 5; n < 8; n++)
      bus(1'b1, NPM_ADDR_CTRL, 32'(n), 1'b1, 32'h0);
    bus(1'b1, NPM_ADDR_CTRL, 32'h11, 1'b1, 32'h0);
    bus(1'b0, NPM_ADDR_CTRL, 32'h4, 1'b0, 32'hffffffff);
    $display("register test done");
    bus(1'b1, NPM_ADDR_CTRL, 32'h14, 1'b0, 32'h0);
    boot(1'b1, NPM_COLD_CYC);
    expect_ports({NPM_NET_ACTIVE, NPM_CHIP_ACTIVE, 9'h0}, 13'h1e00);
    wait_deep(n);
    cmp_count(n, NPM_IDLE_CYC - 5, NPM_IDLE_CYC + 10);
    expect_ports({NPM_NET_DEEP_SLEEP, NPM_CHIP_ACTIVE, 9'h0}, 13'h1e00);
    bus(1'b1, NPM_ADDR_CTRL, 32'h12, 1'b0, 32'h0);
    repeat (3) @(posedge clk);
    expect_ports({NPM_NET_DEEP_SLEEP, NPM_CHIP_DEEP, 9'b100101000}, 13'h1fef);
    bus(1'b0, NPM_ADDR_STATUS, 32'ha1c, 1'b0, 32'hfff);
    rnd = lfsr(rnd);
    // Either block may wake the subsystem on its own
    if (rnd[0])
      net_proc_busy <= 1'b1;
    else
      radio_busy <= 1'b1;
    repeat (3) @(posedge clk);
    expect_ports({NPM_NET_ACTIVE, NPM_CHIP_ACTIVE, 9'b011000000}, 13'h1fc0);
    cmp_count(pulses, 1, 1);
    repeat (rnd[4:1] + 1) @(posedge clk);
    net_proc_busy <= 1'b0;
    radio_busy <= 1'b0;
    net_event <= 1'b1;
    @(posedge clk);
    net_event <= 1'b0;
    repeat (2) @(posedge clk);
    expect_ports({NPM_NET_ACTIVE, 2'h0, 9'b000000100}, 13'h1804);
    repeat (300) @(posedge clk);
    expect_ports({NPM_NET_ACTIVE, 2'h0, 9'b000000100}, 13'h1804);
    bus(1'b0, NPM_ADDR_EVENT, 32'h1, 1'b0, 32'h1);
    repeat (3) @(posedge clk);
    expect_ports(13'h0, 13'h0004);
    wait_deep(n);
    cmp_count(n, NPM_IDLE_CYC - 10, NPM_IDLE_CYC + 10);
    $display("sleep test done");
    foreach (cpu_codes[i])
    begin
      bus(1'b1, NPM_ADDR_CTRL, {27'h0, 2'b10, cpu_codes[i]}, 1'b0, 32'h0);
      repeat (3) @(posedge clk);
      expect_ports({NPM_NET_DEEP_SLEEP, NPM_CHIP_ACTIVE, 9'h0}, 13'h1e00);
    end
    bus(1'b1, NPM_ADDR_CTRL, 32'h4, 1'b0, 32'h0);
    repeat (3) @(posedge clk);
    expect_ports({NPM_NET_DISABLED, NPM_CHIP_ACTIVE, 9'h0}, 13'h1e00);
    bus(1'b1, NPM_ADDR_CTRL, 32'h2, 1'b0, 32'h0);
    repeat (3) @(posedge clk);
    expect_ports({NPM_NET_DISABLED, NPM_CHIP_DEEP, 9'b100111000}, 13'h1ff8);
    bus(1'b1, NPM_ADDR_CTRL, 32'h1, 1'b0, 32'h0);
    repeat (3) @(posedge clk);
    expect_ports({NPM_NET_DISABLED, NPM_CHIP_HIBERNATE, 9'b000010000}, 13'h1ed0);
    bus(1'b1, NPM_ADDR_CTRL, 32'h14, 1'b0, 32'h0);
    boot(1'b0, NPM_WARM_CYC);
    bus(1'b1, NPM_ADDR_CTRL, 32'h0, 1'b0, 32'h0);
    repeat (3) @(posedge clk);
    expect_ports({NPM_NET_DISABLED, NPM_CHIP_SHUTDOWN, 9'h0}, 13'h1e30);
    bus(1'b1, NPM_ADDR_CTRL, 32'h14, 1'b0, 32'h0);
    boot(1'b1, NPM_COLD_CYC);
    $display("mode test done");
    repeat (5) @(posedge clk);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
